/* src/tfc_pkg.sv */
// Package with register map, field layout, reset values and timing of the config bank
package tfc_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_MONITOR_CTRL = 8'h01;
	localparam logic [7:0] ADDR_MEAS_CTRL = 8'h02;
	localparam logic [7:0] ADDR_FAN_POLE = 8'h03;
	localparam logic [7:0] ADDR_PIN_FUNC = 8'h05;

	// Reset values
	localparam logic [7:0] RST_MONITOR_CTRL = 8'h01;
	localparam logic [7:0] RST_MEAS_CTRL = 8'h84;
	localparam logic [7:0] RST_FAN_POLE = 8'h44;
	localparam logic [7:0] RST_PIN_FUNC = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	// Monitor control fields
	localparam int unsigned MC_FAN_AUTO = 7;
	localparam int unsigned MC_LOCK = 6;
	localparam int unsigned MC_SDA_TO = 5;
	localparam int unsigned MC_SCL_TO = 4;
	localparam int unsigned MC_HOT_TIMER = 2;
	localparam int unsigned MC_AVG_OFF = 1;
	localparam int unsigned MC_RUN = 0;

	// Measurement control fields
	localparam int unsigned MS_ROUND_ROBIN = 7;
	localparam int unsigned MS_CHAN_SEL = 4;
	localparam int unsigned MS_LINEAR = 2;
	localparam int unsigned MS_BOOST_DIS = 1;
	localparam int unsigned MS_SOFT_RESTORE = 0;

	// Fan pole field
	localparam int unsigned FP_POLE_LSB = 0;
	localparam int unsigned FP_POLE_W = 4;

	// Pin function fields
	localparam int unsigned PF_REF_SEL = 7;
	localparam int unsigned PF_WIN_LSB = 4;
	localparam int unsigned PF_WIN_W = 3;
	localparam int unsigned PF_XOR_TEST = 3;
	localparam int unsigned PF_REMOTE_OUT = 1;
	localparam int unsigned PF_LOCAL_OUT = 0;

	// Conversion rate code from which averaging is always off (16 per second)
	localparam logic [3:0] RATE_NO_AVG = 4'h8;

	// Duty window: shortest window, longest code shift
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DUTY_BASE_US = 250000;
	localparam int unsigned DUTY_BASE_CYCLES = DUTY_BASE_US * 1000 / CLK_PERIOD_NS;
	localparam logic [2:0] WIN_CODE_MAX = 3'h5;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tfc_reg_req_t;

	typedef struct packed {
		logic fan_auto_select;
		logic wr_locked;
		logic sda_timeout_en;
		logic scl_timeout_en;
		logic hot_pin_timer_en;
		logic averaging_en;
		logic monitor_run;
		logic round_robin;
		logic channel_remote;
		logic speed_curve_linear;
		logic fan_boost;
		logic [3:0] fan_pole_count;
		logic fault_pin_is_ref;
		logic xor_test_en;
	} tfc_cfg_t;

endpackage

/* src/tfc_duty_window.sv */
// Hot pin duty window timer and on-time counter
`timescale 1ns/1ps
module tfc_duty_window import tfc_pkg::*; #(
	parameter int unsigned BASE_CYC = DUTY_BASE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Control
	input wire logic enable_i,
	input wire logic [2:0] window_code_i,
	input wire logic hot_active_i,
	// Results
	output logic window_end_o,
	output logic [31:0] on_cycles_o
);
	logic [2:0] shift_w;
	logic [31:0] limit_w;
	logic [31:0] cnt_q;
	logic [31:0] on_q;
	logic end_w;

	// Codes above the longest window all select it
	assign shift_w = (window_code_i > WIN_CODE_MAX) ? WIN_CODE_MAX : window_code_i;
	assign limit_w = (32'(BASE_CYC) << shift_w) - 32'h1;
	assign end_w = enable_i && (cnt_q >= limit_w);

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || !enable_i || end_w) begin
			cnt_q <= 32'h0;
			on_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			on_q <= on_q + {31'h0, hot_active_i};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			window_end_o <= 1'b0;
			on_cycles_o <= 32'h0;
		end else begin
			window_end_o <= end_w;
			if (end_w) begin
				on_cycles_o <= on_q + {31'h0, hot_active_i};
			end
		end
	end
endmodule

/* src/tfc_hot_pin.sv */
// Open-drain hot-limit pin: input sensing and event drive
`timescale 1ns/1ps
module tfc_hot_pin (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Control
	input wire logic timer_en_i,
	input wire logic local_out_en_i,
	input wire logic remote_out_en_i,
	input wire logic local_hot_i,
	input wire logic remote_hot_i,
	// Pin, active low
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	// Sensed assertion from outside
	output logic ext_active_o
);
	logic drive_w;

	assign drive_w = timer_en_i && ((remote_out_en_i && remote_hot_i)
		|| (local_out_en_i && local_hot_i));

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
			ext_active_o <= 1'b0;
		end else begin
			pin_o <= 1'b0;
			pin_oe_o <= drive_w;
			// Only counted as input while the timer owns it; our own drive is ignored
			ext_active_o <= timer_en_i && !pin_i && !pin_oe_o;
		end
	end
endmodule

/* src/tfc_cfg_bank.sv */
// Configuration register bank of the thermal monitor and fan controller
`timescale 1ns/1ps
module tfc_cfg_bank import tfc_pkg::*; #(
	parameter int unsigned DUTY_BASE_CYC = DUTY_BASE_CYCLES,
	parameter int unsigned XOR_W = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Register access from the serial port engine
	input wire tfc_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_wr_refused_o,
	// Measurement side status
	input wire logic [3:0] conv_rate_i,
	input wire logic local_hot_i,
	input wire logic remote_hot_i,
	input wire logic hot_timer_over_i,
	// Connectivity test chain
	input wire logic [XOR_W-1:0] xor_chain_i,
	output logic xor_chain_o,
	// Hot-limit pin, open drain
	input wire logic hot_limit_pin_i,
	output logic hot_limit_pin_o,
	output logic hot_limit_pin_oe_o,
	// Configuration and events to the rest of the device
	output tfc_cfg_t cfg_o,
	output logic soft_restore_o,
	output logic hot_in_active_o,
	output logic duty_window_end_o,
	output logic [31:0] hot_on_cycles_o
);
	logic [7:0] monitor_ctrl_q;
	logic [7:0] monitor_ctrl_d;
	logic [7:0] meas_ctrl_q;
	logic [7:0] meas_ctrl_d;
	logic [7:0] fan_pole_q;
	logic [7:0] fan_pole_d;
	logic [7:0] pin_func_q;
	logic [7:0] pin_func_d;
	logic lock_q;
	logic lock_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic refused_q;
	logic restore_q;
	logic xor_q;
	tfc_cfg_t cfg_q;
	tfc_cfg_t cfg_d;

	// Address decode
	wire hit_monitor = (reg_req_i.addr == ADDR_MONITOR_CTRL);
	wire hit_meas = (reg_req_i.addr == ADDR_MEAS_CTRL);
	wire hit_pole = (reg_req_i.addr == ADDR_FAN_POLE);
	wire hit_pin = (reg_req_i.addr == ADDR_PIN_FUNC);
	wire hit_any = hit_monitor || hit_meas || hit_pole || hit_pin;

	// Write qualification: every register of this bank is lockable
	wire wr_allowed = reg_req_i.wr && !lock_q;
	wire wr_refused = reg_req_i.wr && lock_q && hit_any;
	wire wr_monitor = wr_allowed && hit_monitor;
	wire wr_meas = wr_allowed && hit_meas;
	wire wr_pole = wr_allowed && hit_pole;
	wire wr_pin = wr_allowed && hit_pin;

	// Soft restore request, taken only from an accepted write
	wire restore_req = wr_meas && reg_req_i.wdata[MS_SOFT_RESTORE];

	// Lock is sticky: once set only the power-on reset releases it
	wire lock_set = wr_monitor && reg_req_i.wdata[MC_LOCK];
	assign lock_d = lock_q || lock_set;

	// Next register values; restore wins over a plain write in the same cycle
	always_comb begin
		monitor_ctrl_d = monitor_ctrl_q;
		meas_ctrl_d = meas_ctrl_q;
		fan_pole_d = fan_pole_q;
		pin_func_d = pin_func_q;
		if (restore_req) begin
			monitor_ctrl_d = RST_MONITOR_CTRL;
			meas_ctrl_d = RST_MEAS_CTRL;
			fan_pole_d = RST_FAN_POLE;
			pin_func_d = RST_PIN_FUNC;
		end else begin
			if (wr_monitor) begin
				monitor_ctrl_d = reg_req_i.wdata;
			end
			if (wr_meas) begin
				meas_ctrl_d = reg_req_i.wdata;
			end
			if (wr_pole) begin
				// Odd pole counts are the host's mistake and are stored as written
				fan_pole_d = reg_req_i.wdata;
			end
			if (wr_pin) begin
				pin_func_d = reg_req_i.wdata;
			end
		end
		// The restore bit never reads back as one
		meas_ctrl_d[MS_SOFT_RESTORE] = 1'b0;
		// Lock bit in the register mirrors the sticky flag
		monitor_ctrl_d[MC_LOCK] = lock_d;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			monitor_ctrl_q <= RST_MONITOR_CTRL;
			meas_ctrl_q <= RST_MEAS_CTRL;
			fan_pole_q <= RST_FAN_POLE;
			pin_func_q <= RST_PIN_FUNC;
			lock_q <= 1'b0;
		end else begin
			monitor_ctrl_q <= monitor_ctrl_d;
			meas_ctrl_q <= meas_ctrl_d;
			fan_pole_q <= fan_pole_d;
			pin_func_q <= pin_func_d;
			lock_q <= lock_d;
		end
	end

	// Read path; reads ignore the lock
	always_comb begin
		rdata_d = rdata_q;
		if (reg_req_i.rd) begin
			if (hit_monitor) begin
				rdata_d = monitor_ctrl_q;
			end else if (hit_meas) begin
				rdata_d = meas_ctrl_q;
			end else if (hit_pole) begin
				rdata_d = fan_pole_q;
			end else if (hit_pin) begin
				rdata_d = pin_func_q;
			end else begin
				rdata_d = RDATA_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rdata_q <= RDATA_UNMAPPED;
			refused_q <= 1'b0;
			restore_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			refused_q <= wr_refused;
			restore_q <= restore_req;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign reg_wr_refused_o = refused_q;
	assign soft_restore_o = restore_q;

	// Averaging is forced off at the fast rates regardless of the control bit
	wire fast_rate = (conv_rate_i >= RATE_NO_AVG);
	wire avg_on = !monitor_ctrl_q[MC_AVG_OFF] && !fast_rate;

	// Boost on hot conditions unless suppressed; then the last speed holds
	wire hot_any = local_hot_i || remote_hot_i || hot_timer_over_i;
	wire boost = hot_any && !meas_ctrl_q[MS_BOOST_DIS];

	// Decoded configuration, registered so every output comes from a flop
	always_comb begin
		cfg_d.fan_auto_select = monitor_ctrl_q[MC_FAN_AUTO];
		cfg_d.wr_locked = lock_q;
		cfg_d.sda_timeout_en = monitor_ctrl_q[MC_SDA_TO];
		cfg_d.scl_timeout_en = monitor_ctrl_q[MC_SCL_TO];
		cfg_d.hot_pin_timer_en = monitor_ctrl_q[MC_HOT_TIMER];
		cfg_d.averaging_en = avg_on;
		cfg_d.monitor_run = monitor_ctrl_q[MC_RUN];
		cfg_d.round_robin = meas_ctrl_q[MS_ROUND_ROBIN];
		cfg_d.channel_remote = meas_ctrl_q[MS_CHAN_SEL];
		cfg_d.speed_curve_linear = meas_ctrl_q[MS_LINEAR];
		cfg_d.fan_boost = boost;
		cfg_d.fan_pole_count = fan_pole_q[FP_POLE_LSB +: FP_POLE_W];
		cfg_d.fault_pin_is_ref = pin_func_q[PF_REF_SEL];
		cfg_d.xor_test_en = pin_func_q[PF_XOR_TEST];
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			cfg_q <= '0;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	assign cfg_o = cfg_q;

	// Connectivity test: parity of the pin chain, held low when the test is off
	wire xor_parity = ^xor_chain_i;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			xor_q <= 1'b0;
		end else begin
			xor_q <= pin_func_q[PF_XOR_TEST] && xor_parity;
		end
	end

	assign xor_chain_o = xor_q;

	// Hot-limit pin driver and sensing
	tfc_hot_pin u_hot_pin (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.timer_en_i(monitor_ctrl_q[MC_HOT_TIMER]),
		.local_out_en_i(pin_func_q[PF_LOCAL_OUT]),
		.remote_out_en_i(pin_func_q[PF_REMOTE_OUT]),
		.local_hot_i(local_hot_i),
		.remote_hot_i(remote_hot_i),
		.pin_i(hot_limit_pin_i),
		.pin_o(hot_limit_pin_o),
		.pin_oe_o(hot_limit_pin_oe_o),
		.ext_active_o(hot_in_active_o)
	);

	// Duty window runs only while the timer is enabled; window code comes straight from the bank
	tfc_duty_window #(
		.BASE_CYC(DUTY_BASE_CYC)
	) u_duty (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.enable_i(monitor_ctrl_q[MC_HOT_TIMER]),
		.window_code_i(pin_func_q[PF_WIN_LSB +: PF_WIN_W]),
		.hot_active_i(hot_in_active_o),
		.window_end_o(duty_window_end_o),
		.on_cycles_o(hot_on_cycles_o)
	);
endmodule

/* dv/tfc_cfg_bank_properties.sv */
// Port relations of the config bank
`timescale 1ns/1ps
module tfc_cfg_bank_properties import tfc_pkg::*; #(
	parameter int unsigned DUTY_BASE_CYC = DUTY_BASE_CYCLES,
	parameter int unsigned XOR_W = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Watched ports
	input wire tfc_reg_req_t reg_req_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_wr_refused_o,
	input wire logic [3:0] conv_rate_i,
	input wire logic local_hot_i,
	input wire logic remote_hot_i,
	input wire logic hot_timer_over_i,
	input wire logic [XOR_W-1:0] xor_chain_i,
	input wire logic xor_chain_o,
	input wire logic hot_limit_pin_o,
	input wire logic hot_limit_pin_oe_o,
	input wire tfc_cfg_t cfg_o,
	input wire logic soft_restore_o
);
	wire mapped = reg_req_i.addr inside {ADDR_MONITOR_CTRL, ADDR_MEAS_CTRL, ADDR_FAN_POLE,
		ADDR_PIN_FUNC};
	wire rst_wr = reg_req_i.wr && reg_req_i.addr == ADDR_MEAS_CTRL &&
		reg_req_i.wdata[MS_SOFT_RESTORE];
	wire temp_hot = local_hot_i | remote_hot_i;
	wire any_hot = temp_hot | hot_timer_over_i;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	AST_LOCK_REFUSE: assert property (reg_req_i.wr && mapped && cfg_o.wr_locked |=>
		reg_wr_refused_o) else $error("locked write not refused");
	AST_REFUSE_CAUSE: assert property (reg_wr_refused_o |-> $past(reg_req_i.wr))
		else $error("refusal without write");
	AST_RD_HOLD: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
		else $error("read data moved without read");
	AST_RESTORE_CAUSE: assert property (soft_restore_o |-> $past(rst_wr))
		else $error("restore pulse without write");
	AST_RESTORE_CFG: assert property (soft_restore_o |=> cfg_o.monitor_run &&
		cfg_o.round_robin && cfg_o.speed_curve_linear && cfg_o.fan_pole_count == 4'h4 &&
		!cfg_o.fan_auto_select) else $error("restore left config changed");
	AST_AVG_FAST: assert property (conv_rate_i >= RATE_NO_AVG &&
		$past(conv_rate_i) >= RATE_NO_AVG |-> !cfg_o.averaging_en)
		else $error("averaging on at fast rate");
	AST_BOOST_CAUSE: assert property (cfg_o.fan_boost |-> $past(any_hot))
		else $error("boost without hot cause");
	AST_OE_CAUSE: assert property ($rose(hot_limit_pin_oe_o) |-> $past(temp_hot))
		else $error("pin driven without hot");
	AST_OE_DROP: assert property (!temp_hot [*2] |=> !hot_limit_pin_oe_o)
		else $error("pin still driven");
	AST_PIN_LOW: assert property (hot_limit_pin_o == 1'b0)
		else $error("pin driven high");
	AST_XOR: assert property (cfg_o.xor_test_en && $past(cfg_o.xor_test_en) |->
		xor_chain_o == ^$past(xor_chain_i)) else $error("chain parity wrong");
	cover property (soft_restore_o);
	cover property (reg_wr_refused_o);
	cover property ($rose(hot_limit_pin_oe_o));
endmodule

/* dv/tfc_host_model.sv */
// Register port host standing for the serial engine
`timescale 1ns/1ps
module tfc_host_model import tfc_pkg::*; (
	// Clock
	input wire logic clk_sys_i,
	// Register port
	output tfc_reg_req_t req_o,
	input wire logic [7:0] rdata_i,
	input wire logic refused_i
);
	initial req_o = '0;
	// Idle lines show the inverse so a stale value never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic rf);
		@(posedge clk_sys_i);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		@(negedge clk_sys_i);
		rf = refused_i;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		@(negedge clk_sys_i);
		d = rdata_i;
	endtask
endmodule

/* dv/tfc_cfg_bank_tb.sv */
// Self-checking bench of the config bank
`timescale 1ns/1ps
module tfc_cfg_bank_tb import tfc_pkg::*;;
	localparam int BASE = 8;
	logic clk_sys_i, rstn_i, local_hot_i, remote_hot_i, hot_timer_over_i, ext_low, rf;
	logic reg_wr_refused_o, xor_chain_o, hot_limit_pin_o, hot_limit_pin_oe_o, soft_restore_o;
	logic hot_in_active_o, duty_window_end_o;
	logic [3:0] conv_rate_i;
	logic [7:0] xor_chain_i, reg_rdata_o, rv;
	logic [31:0] hot_on_cycles_o;
	tfc_reg_req_t reg_req_i;
	tfc_cfg_t cfg_o;
	int bad_count = 0, n_compared = 0, cyc = 0;
	// Pulled-up open-drain wire
	wire logic hot_limit_pin_i = ~(hot_limit_pin_oe_o | ext_low);
	tfc_cfg_bank #(.DUTY_BASE_CYC(BASE), .XOR_W(8)) i_dut (.clk_sys_i, .rstn_i, .reg_req_i,
		.reg_rdata_o, .reg_wr_refused_o, .conv_rate_i, .local_hot_i, .remote_hot_i,
		.hot_timer_over_i, .xor_chain_i, .xor_chain_o, .hot_limit_pin_i, .hot_limit_pin_o,
		.hot_limit_pin_oe_o, .cfg_o, .soft_restore_o, .hot_in_active_o, .duty_window_end_o,
		.hot_on_cycles_o);
	tfc_host_model i_host (.clk_sys_i, .req_o(reg_req_i), .rdata_i(reg_rdata_o),
		.refused_i(reg_wr_refused_o));
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic nc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic wrc(input logic [7:0] a, input logic [7:0] d);
		i_host.wr(a, d, rf);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		i_host.rd(a, rv);
		chk(rv, e);
	endtask
	task automatic wend(output int n);
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (duty_window_end_o !== 1'b1 && n < 600);
	endtask
	task automatic t_reset;
		nc(2);
		chk({cfg_o.monitor_run, cfg_o.round_robin, cfg_o.speed_curve_linear,
			cfg_o.fan_pole_count}, 7'h74);
		chk({cfg_o.fan_auto_select, cfg_o.wr_locked, cfg_o.sda_timeout_en, cfg_o.scl_timeout_en,
			cfg_o.hot_pin_timer_en, cfg_o.averaging_en}, 6'h01);
		rdc(ADDR_MONITOR_CTRL, RST_MONITOR_CTRL);
		rdc(ADDR_MEAS_CTRL, RST_MEAS_CTRL);
		rdc(ADDR_FAN_POLE, RST_FAN_POLE);
		rdc(ADDR_PIN_FUNC, RST_PIN_FUNC);
		rdc(8'h04, RDATA_UNMAPPED);
	endtask
	task automatic t_fields;
		wrc(ADDR_MONITOR_CTRL, 8'hB6);
		nc(1);
		chk({cfg_o.fan_auto_select, cfg_o.wr_locked, cfg_o.sda_timeout_en, cfg_o.scl_timeout_en,
			cfg_o.hot_pin_timer_en, cfg_o.averaging_en, cfg_o.monitor_run}, 7'h5C);
		wrc(ADDR_MONITOR_CTRL, 8'h01);
		for (int i = 7; i < 11; i++) begin
			@(posedge clk_sys_i) conv_rate_i <= 4'(i);
			nc(3);
			chk(cfg_o.averaging_en, i < 8);
		end
		wrc(ADDR_MEAS_CTRL, 8'h12);
		@(posedge clk_sys_i) hot_timer_over_i <= 1'b1;
		nc(3);
		chk({cfg_o.round_robin, cfg_o.channel_remote, cfg_o.speed_curve_linear}, 3'h2);
		chk(cfg_o.fan_boost, 1'b0);
		wrc(ADDR_MEAS_CTRL, 8'h10);
		nc(1);
		chk(cfg_o.fan_boost, 1'b1);
		@(posedge clk_sys_i) hot_timer_over_i <= 1'b0;
		wrc(ADDR_FAN_POLE, 8'h06);
		rdc(ADDR_FAN_POLE, 8'h06);
		chk(cfg_o.fan_pole_count, 4'h6);
	endtask
	task automatic t_hot;
		wrc(ADDR_PIN_FUNC, 8'h89);
		@(posedge clk_sys_i) xor_chain_i <= 8'h07;
		nc(3);
		chk({cfg_o.fault_pin_is_ref, cfg_o.xor_test_en, xor_chain_o}, 3'h7);
		wrc(ADDR_MONITOR_CTRL, 8'h05);
		@(posedge clk_sys_i) remote_hot_i <= 1'b1;
		nc(3);
		chk(hot_limit_pin_oe_o, 1'b0);
		@(posedge clk_sys_i) local_hot_i <= 1'b1;
		nc(3);
		chk({hot_limit_pin_oe_o, hot_limit_pin_i, hot_limit_pin_o}, 3'h4);
		@(posedge clk_sys_i) local_hot_i <= 1'b0;
		wrc(ADDR_PIN_FUNC, 8'h02);
		nc(3);
		chk({hot_limit_pin_oe_o, xor_chain_o}, 2'h2);
		wrc(ADDR_MONITOR_CTRL, 8'h01);
		nc(3);
		chk(hot_limit_pin_oe_o, 1'b0);
		@(posedge clk_sys_i) remote_hot_i <= 1'b0;
	endtask
	task automatic t_duty;
		int n;
		int e;
		wrc(ADDR_MONITOR_CTRL, 8'h05);
		@(posedge clk_sys_i) ext_low <= 1'b1;
		// Every window code, the three longest all select the same window
		for (int i = 0; i < 8; i++) begin
			e = BASE << (i > 5 ? 5 : i);
			wrc(ADDR_PIN_FUNC, {1'b0, 3'(i), 4'h0});
			wend(n);
			wend(n);
			wend(n);
			chk(n, e);
			chk(hot_on_cycles_o, e);
		end
		chk(hot_in_active_o, 1'b1);
		@(posedge clk_sys_i) ext_low <= 1'b0;
	endtask
	task automatic t_restore;
		wrc(ADDR_MONITOR_CTRL, 8'hB4);
		wrc(ADDR_MEAS_CTRL, 8'h13);
		chk(soft_restore_o, 1'b1);
		nc(1);
		chk(soft_restore_o, 1'b0);
		rdc(ADDR_MEAS_CTRL, RST_MEAS_CTRL);
		rdc(ADDR_MONITOR_CTRL, RST_MONITOR_CTRL);
		rdc(ADDR_FAN_POLE, RST_FAN_POLE);
		rdc(ADDR_PIN_FUNC, RST_PIN_FUNC);
	endtask
	task automatic t_lock;
		logic [7:0] ad[4] = '{ADDR_MONITOR_CTRL, ADDR_MEAS_CTRL, ADDR_FAN_POLE, ADDR_PIN_FUNC};
		wrc(ADDR_MONITOR_CTRL, 8'h41);
		chk(rf, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wrc(ad[i], 8'h01);
			chk({rf, soft_restore_o}, 2'h2);
		end
		wrc(8'h04, 8'h00);
		chk(rf, 1'b0);
		rdc(ADDR_MONITOR_CTRL, 8'h41);
		rdc(ADDR_MEAS_CTRL, RST_MEAS_CTRL);
		@(posedge clk_sys_i) rstn_i <= 1'b0;
		@(posedge clk_sys_i) rstn_i <= 1'b1;
		wrc(ADDR_MONITOR_CTRL, 8'h00);
		chk(rf, 1'b0);
		rdc(ADDR_MONITOR_CTRL, 8'h00);
	endtask
	initial begin
		rstn_i = 1'b0;
		conv_rate_i = 4'h0;
		local_hot_i = 1'b0;
		remote_hot_i = 1'b0;
		hot_timer_over_i = 1'b0;
		xor_chain_i = 8'h00;
		ext_low = 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		t_reset;
		t_fields;
		t_hot;
		t_duty;
		t_restore;
		t_lock;
		final_report;
	end
endmodule
bind tfc_cfg_bank tfc_cfg_bank_properties #(.DUTY_BASE_CYC(DUTY_BASE_CYC), .XOR_W(XOR_W))
	i_props (.clk_sys_i, .rstn_i, .reg_req_i, .reg_rdata_o, .reg_wr_refused_o, .conv_rate_i,
	.local_hot_i, .remote_hot_i, .hot_timer_over_i, .xor_chain_i, .xor_chain_o,
	.hot_limit_pin_o, .hot_limit_pin_oe_o, .cfg_o, .soft_restore_o);
